// file: pkg/caw_cfg.svh
// constants for the counter array watchdog
// Contract
// - watchdog enabled after every reset
// - module5 high compares counter high; low is offset
// - enabled watchdog forces counter running
// - counter byte writes ignored while enabled
// - timebase select and idle bit frozen
// - module5 software timer; mode writes ignored
// - run bit writes leave counter running
// - run bit reads software value, zero if unset
// - compare-high write reloads counter high plus offset
// - reset on low overflow during high match
// - timeout is 256*offset plus 256 minus low
// - writing 1 to module5 flag forces reset
// - enable bit or lock bit enables watchdog
// - lock holds watchdog enabled until reset
// - unlocked, clearing enable disables watchdog
// - reset defaults: divide by 12, zero bytes
// - overflow flag set on counter wrap, sticky
// - run bit stops or runs counter
// - module flags set by hardware, sticky
// - mode register writes ignored while enabled, except the enable and lock bits
// - timebase select codes as documented
// - idle-suspend bit pauses counter in idle
`ifndef CAW_CFG_SVH
`define CAW_CFG_SVH
`define CAW_ADDR_CTRL 8'hd8
`define CAW_ADDR_MODE 8'hd9
`define CAW_ADDR_CNT_LO 8'hf9
`define CAW_ADDR_CNT_HI 8'hfa
`define CAW_ADDR_M5_LO 8'hce
`define CAW_ADDR_M5_HI 8'hcf
`define CAW_ADDR_M5_MODE 8'hde
`define CAW_CTRL_RESET 8'h00
`define CAW_MODE_RESET 8'h40
`define CAW_M5_MODE_RESET 8'h00
`define CAW_M5_MODE_SWTIMER 8'h48
`define CAW_BIT_OVF 7
`define CAW_BIT_RUN 6
`define CAW_BIT_M5 5
`define CAW_BIT_IDLE 7
`define CAW_BIT_WDEN 6
`define CAW_BIT_LOCK 5
`define CAW_BIT_UNUSED 4
`define CAW_BIT_OVF_IE 0
`define CAW_TB_LSB 1
`define CAW_TB_MSB 3
`define CAW_TB_DIV12 3'h0
`define CAW_TB_DIV4 3'h1
`define CAW_TB_TMR0 3'h2
`define CAW_TB_ECI 3'h3
`define CAW_TB_SYS 3'h4
`define CAW_TB_EXT8 3'h5
`define CAW_DIV12 4'hb
`define CAW_DIV4 4'h3
`define CAW_DIV8 3'h7
`endif

// file: pkg/caw_pkg.sv
// types for the counter array watchdog
package caw_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } caw_sfr_req_t;
  typedef struct packed {
    logic sys_tick;
    logic tmr0_ovf;
    logic eci_level;
    logic ext_tick;
    logic cpu_idle;
  } caw_src_t;
endpackage

// file: verilog/caw_tick_gen.sv
// timebase tick generator for the counter array
`timescale 1ns/10ps
`include "caw_cfg.svh"
module caw_tick_gen
  import caw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [2:0] sel_i,
  input wire caw_pkg::caw_src_t src_i,
  output logic tick_o
);
  logic [3:0] div_reg, div_next;
  logic [2:0] ext_reg, ext_next;
  logic eci_reg, eci_next;
  logic tick_reg, tick_next;

  // ----------------------------------------
  // source select
  // ----------------------------------------
  always_comb begin
    div_next = div_reg;
    ext_next = ext_reg;
    eci_next = src_i.eci_level;
    tick_next = 1'b0;
    if (src_i.sys_tick) begin
      div_next = div_reg + 4'h1;
    end
    if (src_i.ext_tick) begin
      ext_next = ext_reg + 3'h1;
    end
    case (sel_i)
      `CAW_TB_DIV12: begin
        if (src_i.sys_tick && div_reg >= `CAW_DIV12) begin
          div_next = 4'h0;
          tick_next = 1'b1;
        end
      end
      `CAW_TB_DIV4: begin
        if (src_i.sys_tick && div_reg >= `CAW_DIV4) begin
          div_next = 4'h0;
          tick_next = 1'b1;
        end
      end
      `CAW_TB_TMR0: tick_next = src_i.tmr0_ovf;
      `CAW_TB_ECI: tick_next = eci_reg & ~src_i.eci_level;
      `CAW_TB_SYS: tick_next = src_i.sys_tick;
      `CAW_TB_EXT8: tick_next = src_i.ext_tick && ext_reg == `CAW_DIV8;
      default: tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_reg <= 4'h0;
      ext_reg <= 3'h0;
      eci_reg <= 1'b1;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      ext_reg <= ext_next;
      eci_reg <= eci_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule

// file: verilog/caw_watchdog.sv
// counter array with module5 watchdog
`timescale 1ns/10ps
`include "caw_cfg.svh"
module caw_watchdog
  import caw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire caw_pkg::caw_sfr_req_t sfr_i,
  input wire caw_pkg::caw_src_t src_i,
  input wire logic [4:0] module_event_i,
  output logic [7:0] rdata_o,
  output logic wdt_reset_o,
  output logic array_irq_o,
  output logic watchdog_active_o
);
  import caw_pkg::*;

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] m5_mode_reg, m5_mode_next;
  logic [7:0] cnt_lo_reg, cnt_lo_next;
  logic [7:0] cnt_hi_reg, cnt_hi_next;
  logic [7:0] m5_lo_reg, m5_lo_next;
  logic [7:0] m5_hi_reg, m5_hi_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wdrst_reg, wdrst_next;
  logic irq_reg, irq_next;
  logic tick;
  logic wd_en;
  logic running;
  logic advance;
  logic lo_wrap;
  logic full_wrap;
  logic m5_match;
  logic wr_ctrl, wr_mode, wr_m5_mode;

  caw_tick_gen u_tick (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .sel_i(mode_reg[`CAW_TB_MSB:`CAW_TB_LSB]),
    .src_i(src_i),
    .tick_o(tick)
  );

  // ----------------------------------------
  // watchdog status and counter advance
  // ----------------------------------------
  assign wd_en = mode_reg[`CAW_BIT_WDEN] | mode_reg[`CAW_BIT_LOCK];
  assign running = wd_en | ctrl_reg[`CAW_BIT_RUN];
  assign advance = running & tick
    & ~(mode_reg[`CAW_BIT_IDLE] & src_i.cpu_idle);
  assign lo_wrap = advance && cnt_lo_reg == 8'hff;
  assign full_wrap = lo_wrap && cnt_hi_reg == 8'hff;
  assign wr_ctrl = sfr_i.wr && sfr_i.addr == `CAW_ADDR_CTRL;
  assign wr_mode = sfr_i.wr && sfr_i.addr == `CAW_ADDR_MODE;
  assign wr_m5_mode = sfr_i.wr && sfr_i.addr == `CAW_ADDR_M5_MODE;
  // software timer match: 16-bit compare in normal use
  assign m5_match = advance && m5_mode_reg[0] == 1'b0
    && {cnt_hi_reg, cnt_lo_next} == {m5_hi_reg, m5_lo_reg};

  // ----------------------------------------
  // counter and module5 registers
  // ----------------------------------------
  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    m5_lo_next = m5_lo_reg;
    m5_hi_next = m5_hi_reg;
    m5_mode_next = m5_mode_reg;
    if (advance) begin
      cnt_lo_next = cnt_lo_reg + 8'h01;
      if (lo_wrap) begin
        cnt_hi_next = cnt_hi_reg + 8'h01;
      end
    end
    if (!wd_en) begin
      if (sfr_i.wr && sfr_i.addr == `CAW_ADDR_CNT_LO) begin
        cnt_lo_next = sfr_i.wdata;
      end
      if (sfr_i.wr && sfr_i.addr == `CAW_ADDR_CNT_HI) begin
        cnt_hi_next = sfr_i.wdata;
      end
      if (wr_m5_mode) begin
        m5_mode_next = sfr_i.wdata;
      end
    end else begin
      m5_mode_next = `CAW_M5_MODE_SWTIMER;
    end
    if (sfr_i.wr && sfr_i.addr == `CAW_ADDR_M5_LO) begin
      m5_lo_next = sfr_i.wdata;
    end
    if (sfr_i.wr && sfr_i.addr == `CAW_ADDR_M5_HI) begin
      if (wd_en) begin
        m5_hi_next = 8'(cnt_hi_reg + m5_lo_reg);
      end else begin
        m5_hi_next = sfr_i.wdata;
      end
    end
  end

  // ----------------------------------------
  // control flags and mode register
  // ----------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    mode_next = mode_reg;
    if (wr_ctrl) begin
      ctrl_next = sfr_i.wdata;
    end
    if (full_wrap) begin
      ctrl_next[`CAW_BIT_OVF] = 1'b1;
    end
    for (int i = 0; i < 5; i++) begin
      if (module_event_i[i]) begin
        ctrl_next[i] = 1'b1;
      end
    end
    if (m5_match && !wd_en) begin
      ctrl_next[`CAW_BIT_M5] = 1'b1;
    end
    if (wr_mode) begin
      if (wd_en) begin
        // only enable and lock are writable while armed
        mode_next[`CAW_BIT_LOCK] = mode_reg[`CAW_BIT_LOCK]
          | sfr_i.wdata[`CAW_BIT_LOCK];
        // a fresh lock keeps the enable bit up as well
        mode_next[`CAW_BIT_WDEN] = mode_reg[`CAW_BIT_LOCK]
          | sfr_i.wdata[`CAW_BIT_LOCK]
          | sfr_i.wdata[`CAW_BIT_WDEN];
      end else begin
        mode_next = sfr_i.wdata;
        mode_next[`CAW_BIT_UNUSED] = 1'b0;
        if (sfr_i.wdata[`CAW_BIT_LOCK]) begin
          mode_next[`CAW_BIT_WDEN] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // watchdog reset, interrupt and read data
  // ----------------------------------------
  always_comb begin
    wdrst_next = 1'b0;
    if (wd_en && lo_wrap && m5_hi_reg == cnt_hi_reg) begin
      wdrst_next = 1'b1;
    end
    if (wd_en && wr_ctrl && sfr_i.wdata[`CAW_BIT_M5]) begin
      wdrst_next = 1'b1;
    end
    irq_next = (ctrl_next[`CAW_BIT_OVF] & mode_next[`CAW_BIT_OVF_IE])
      | (|ctrl_next[`CAW_BIT_M5:0]);
    rdata_next = 8'h00;
    if (sfr_i.rd) begin
      case (sfr_i.addr)
        `CAW_ADDR_CTRL: rdata_next = ctrl_reg;
        `CAW_ADDR_MODE: rdata_next = mode_reg;
        `CAW_ADDR_CNT_LO: rdata_next = cnt_lo_reg;
        `CAW_ADDR_CNT_HI: rdata_next = cnt_hi_reg;
        `CAW_ADDR_M5_LO: rdata_next = m5_lo_reg;
        `CAW_ADDR_M5_HI: rdata_next = m5_hi_reg;
        `CAW_ADDR_M5_MODE: rdata_next = m5_mode_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_reg <= `CAW_CTRL_RESET;
      mode_reg <= `CAW_MODE_RESET;
      m5_mode_reg <= `CAW_M5_MODE_RESET;
      cnt_lo_reg <= 8'h00;
      cnt_hi_reg <= 8'h00;
      m5_lo_reg <= 8'h00;
      m5_hi_reg <= 8'h00;
      rdata_reg <= 8'h00;
      wdrst_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
      m5_mode_reg <= m5_mode_next;
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      m5_lo_reg <= m5_lo_next;
      m5_hi_reg <= m5_hi_next;
      rdata_reg <= rdata_next;
      wdrst_reg <= wdrst_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign wdt_reset_o = wdrst_reg;
  assign array_irq_o = irq_reg;
  assign watchdog_active_o = mode_reg[`CAW_BIT_WDEN];
endmodule

// file: sim/caw_monitor.sv
// assertions on the watchdog top ports
`timescale 1ns/10ps
module caw_monitor
  import caw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire caw_pkg::caw_sfr_req_t sfr_i,
  input wire caw_pkg::caw_src_t src_i,
  input wire logic [4:0] module_event_i,
  input wire logic [7:0] rdata_o,
  input wire logic wdt_reset_o,
  input wire logic array_irq_o,
  input wire logic watchdog_active_o
);
  logic lock_reg, lock_next, run_reg, run_next;
  wire logic mode_wr = sfr_i.wr && sfr_i.addr == 8'hd9;
  wire logic ctrl_wr = sfr_i.wr && sfr_i.addr == 8'hd8;
  always_comb begin
    lock_next = lock_reg | (mode_wr & sfr_i.wdata[5]);
    run_next = ctrl_wr ? sfr_i.wdata[6] : run_reg;
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_reg <= 1'b0;
      run_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      run_reg <= run_next;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_force;
    ctrl_wr && sfr_i.wdata[5] && watchdog_active_o;
  endsequence
  sequence s_quiet;
    !watchdog_active_o [*2];
  endsequence
  a_force_reset: assert property (s_force |=> wdt_reset_o)
    else $error("forced reset missing");
  a_reset_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("reset request too long");
  a_armed_boot: assert property (!$past(resetn_i) |-> watchdog_active_o)
    else $error("not armed after reset");
  a_enable_set: assert property (mode_wr && sfr_i.wdata[6:5] != 2'b00 |=> watchdog_active_o)
    else $error("enable write ignored");
  a_unlock_clear: assert property (mode_wr && sfr_i.wdata[6:5] == 2'b00 && !lock_reg
    |=> !watchdog_active_o)
    else $error("disable ignored");
  a_lock_hold: assert property (lock_reg |-> watchdog_active_o)
    else $error("lock released");
  a_run_read: assert property (sfr_i.rd && sfr_i.addr == 8'hd8 |=> rdata_o[6] == run_reg)
    else $error("run bit readback wrong");
  a_idle_quiet: assert property (s_quiet |-> !wdt_reset_o)
    else $error("reset while disabled");
  a_flag_irq: assert property (module_event_i != 5'h00 |-> ##2 array_irq_o)
    else $error("flag irq missing");
endmodule
bind caw_watchdog caw_monitor u_mon (.mclk_i(mclk_i), .resetn_i(resetn_i), .sfr_i(sfr_i),
  .src_i(src_i), .module_event_i(module_event_i), .rdata_o(rdata_o),
  .wdt_reset_o(wdt_reset_o), .array_irq_o(array_irq_o),
  .watchdog_active_o(watchdog_active_o));

// file: sim/caw_cpu_model.sv
// cpu side model issuing register reads and writes
`timescale 1ns/10ps
module caw_cpu_model
  import caw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output caw_pkg::caw_sfr_req_t sfr_o
);
  initial sfr_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sfr_o <= '{1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    sfr_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    sfr_o <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    sfr_o <= '{1'b0, 1'b0, ~a, 8'hff};
    #1 d = rdata_i;
  endtask
  // disable, timebase and idle, offset, enable, refresh
  task automatic setup(input logic [7:0] mode, input logic [7:0] ofs);
    wr(8'hd9, 8'h00);
    wr(8'hd9, mode & 8'h9e);
    wr(8'hce, ofs);
    wr(8'hd9, mode | 8'h40);
    wr(8'hcf, 8'h00);
  endtask
endmodule

// file: sim/caw_watchdog_bench.sv
// self-checking bench for the counter array watchdog
`timescale 1ns/10ps
module caw_watchdog_bench;
  import caw_pkg::*;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  caw_src_t src_i = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [4:0] module_event_i = 5'h00;
  caw_sfr_req_t sfr;
  logic [7:0] rdata_o, rv;
  logic wdt_reset_o, array_irq_o, watchdog_active_o;
  int err_total = 0;
  int total_checks = 0;
  int n;
  always #5 mclk_i = ~mclk_i;
  caw_cpu_model u_cpu (.mclk_i(mclk_i), .rdata_i(rdata_o), .sfr_o(sfr));
  caw_watchdog u_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .sfr_i(sfr), .src_i(src_i),
    .module_event_i(module_event_i), .rdata_o(rdata_o), .wdt_reset_o(wdt_reset_o),
    .array_irq_o(array_irq_o), .watchdog_active_o(watchdog_active_o));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
  endtask
  task automatic time_out(output int cnt);
    cnt = 0;
    while (wdt_reset_o !== 1'b1 && cnt < 4000) begin
      @(posedge mclk_i);
      #1 cnt++;
    end
  endtask
  task automatic t_boot();
    do_reset();
    time_out(n);
    chk(16'(n >= 3066 && n <= 3080), 16'h1);
  endtask
  task automatic t_regs();
    do_reset();
    u_cpu.rd(8'hd9, rv);
    chk(rv, 8'h40);
    u_cpu.rd(8'hd8, rv);
    chk(rv, 8'h00);
    u_cpu.wr(8'hd9, 8'hc8);
    u_cpu.rd(8'hd9, rv);
    chk(rv, 8'h40);
    u_cpu.wr(8'hd9, 8'h00);
    u_cpu.wr(8'hd9, 8'h8a);
    u_cpu.rd(8'hd9, rv);
    chk(rv, 8'h8a);
    u_cpu.wr(8'hf9, 8'h5a);
    u_cpu.rd(8'hf9, rv);
    chk(rv, 8'h5a);
    u_cpu.wr(8'hd9, 8'h08);
    u_cpu.wr(8'hfa, 8'hff);
    u_cpu.wr(8'hf9, 8'hfe);
    u_cpu.wr(8'hd8, 8'h40);
    repeat (8) @(posedge mclk_i);
    u_cpu.rd(8'hd8, rv);
    chk(rv[7:6], 2'b11);
  endtask
  task automatic t_refresh();
    u_cpu.wr(8'hd8, 8'h00);
    u_cpu.wr(8'hfa, 8'h00);
    u_cpu.wr(8'hf9, 8'h00);
    u_cpu.setup(8'h08, 8'h01);
    time_out(n);
    chk(16'(n >= 500 && n <= 516), 16'h1);
  endtask
  task automatic t_force_lock();
    do_reset();
    u_cpu.wr(8'hd8, 8'h20);
    #1 chk(wdt_reset_o, 1'b1);
    @(posedge mclk_i);
    #1 chk(wdt_reset_o, 1'b0);
    u_cpu.wr(8'hd9, 8'h20);
    u_cpu.wr(8'hd9, 8'h00);
    #1 chk(watchdog_active_o, 1'b1);
    @(posedge mclk_i);
    module_event_i <= 5'h01;
    @(posedge mclk_i);
    module_event_i <= 5'h00;
    u_cpu.rd(8'hd8, rv);
    chk(rv[0], 1'b1);
    chk(array_irq_o, 1'b1);
  endtask
  initial begin
    t_boot();
    t_regs();
    t_refresh();
    t_force_lock();
    report_and_stop();
  end
  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
endmodule
